// [bench/adc_output_format_control_tb.sv]
// Self-checking bench for the output format control block
`timescale 1ns/1ps
module adc_output_format_control_tb;
    logic        clock_in, nrst_in, reg_wr_in, reg_rd_in, div_active_in, sample_req_in;
    logic        bit_tick_in, sample_strobe_out, frame_clock_out, data_clock_out;
    logic        reduced_swing_out, clk_drive_2x_out, pulldown_off_out, cm_gen_pd_out;
    logic [9:0]  reg_addr_in, out_clk_deg_out;
    logic [7:0]  reg_wdata_in, reg_rdata_out, rate_limit_out, ov;
    logic [3:0]  clk_chan_sel_in, out_clk_phase_out, dclk_mult_out;
    logic [2:0]  div_ratio_in;
    logic [15:0] sample_in, rx_word, rx_clk, s;
    logic [1:0]  lanes, termination_out;
    int          err_count, compares, n, v, rm [int];
    int          keys [7] = '{'h14, 'h15, 'h16, 'h21, 'h100, 'h101, 'h102};
    int          modes [6] = '{'h20, 'h10, 'h00, 'h34, 'h24, 'h30};
    aofc_core u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .clk_chan_sel_in(clk_chan_sel_in), .div_ratio_in(div_ratio_in),
        .div_active_in(div_active_in), .sample_req_in(sample_req_in), .sample_in(sample_in),
        .bit_tick_in(bit_tick_in), .reg_rdata_out(reg_rdata_out),
        .sample_strobe_out(sample_strobe_out), .data_lane_pairs_out(lanes),
        .frame_clock_out(frame_clock_out), .data_clock_out(data_clock_out),
        .dclk_mult_out(dclk_mult_out), .reduced_swing_out(reduced_swing_out),
        .clk_drive_2x_out(clk_drive_2x_out), .termination_out(termination_out),
        .out_clk_phase_out(out_clk_phase_out), .out_clk_deg_out(out_clk_deg_out),
        .rate_limit_out(rate_limit_out), .pulldown_off_out(pulldown_off_out),
        .cm_gen_pd_out(cm_gen_pd_out));
    aofc_rx_model u_rx (.clock_in(clock_in), .nrst_in(nrst_in), .bit_tick_in(bit_tick_in),
        .lanes_in(lanes), .frame_in(frame_clock_out), .dclk_in(data_clock_out),
        .word_out(rx_word), .clk_out(rx_clk));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (rm.exists(a)) rm[a] = d;
        @(posedge clock_in) reg_wr_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
    endtask
    task automatic rdc(input logic [9:0] a);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in) reg_rd_in <= 1'b0;
        #1 chk("readback", reg_rdata_out, rm.exists(a) ? rm[a] : 0);
    endtask
    task automatic strobe_delay;
        @(posedge clock_in) sample_req_in <= 1'b1;
        @(posedge clock_in) sample_req_in <= 1'b0;
        n = 0;
        #1;
        while (sample_strobe_out !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            #1 n++;
        end
        if (n == 20) begin
            err_count++;
            complete_run();
        end
    endtask
    initial begin
        {nrst_in, reg_wr_in, reg_rd_in, div_active_in, sample_req_in, bit_tick_in} = '0;
        {reg_addr_in, reg_wdata_in, clk_chan_sel_in, sample_in} = '0;
        div_ratio_in = 3'h7;
        foreach (keys[i]) rm[keys[i]] = 0;
        rm['h14] = 'h01;
        rm['h21] = 'h30;
        v = $urandom(32'h959b44b5);
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        foreach (keys[i]) rdc(keys[i][9:0]);
        rdc(10'h3ff);
        chk("dclk mult", dclk_mult_out, 3'h4);
        repeat (6) begin
            v = $urandom;
            wr(10'h014, v[7:0] & 8'hfa);
            chk("swing", reduced_swing_out, v[6]);
            wr(10'h015, v[7:0] & 8'h30);
            chk("termination", termination_out, v[5:4]);
            wr(10'h016, 8'(v[15:8] % 12));
            chk("phase deg", out_clk_deg_out, (v[15:8] % 12) * 60);
            wr(10'h101, v[23:16]);
            chk("pull-down", pulldown_off_out, v[16]);
            wr(10'h102, v[31:24]);
            chk("cm off", cm_gen_pd_out, v[27]);
            foreach (keys[i]) if (keys[i] != 'h100) rdc(keys[i][9:0]);
        end
        wr(10'h015, 8'h01);
        chk("drive no chan", clk_drive_2x_out, 1'b0);
        @(posedge clock_in) clk_chan_sel_in <= 4'h1;
        wr(10'h015, 8'h01);
        chk("drive 2x", clk_drive_2x_out, 1'b1);
        wr(10'h015, 8'h31);
        chk("drive vs term", clk_drive_2x_out, 1'b0);
        foreach (modes[i]) begin
            wr(10'h021, modes[i][7:0]);
            chk("dclk mult", dclk_mult_out, modes[i][5] ? 4'h4 : 4'h8);
        end
        ov = 8'($urandom) | 8'h01;
        wr(10'h100, ov);
        chk("override held", rate_limit_out, 8'h00);
        rdc(10'h100);
        wr(10'h0ff, 8'h01);
        chk("override taken", rate_limit_out, ov);
        wr(10'h100, 8'h00);
        chk("override held", rate_limit_out, ov);
        @(posedge clock_in) div_active_in <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            wr(10'h016, 8'(p << 4));
            strobe_delay();
            chk("phase delay", n, p);
        end
        @(posedge clock_in) div_active_in <= 1'b0;
        strobe_delay();
        chk("phase no divider", n, 0);
        // Drain the word that the strobe tests left in the serializer
        repeat (16) @(posedge clock_in) bit_tick_in <= ~bit_tick_in;
        for (int i = 0; i < 4; i++) begin
            wr(10'h014, 8'((i & 2) << 1 | (i & 1)));
            s = 16'($urandom);
            @(posedge clock_in) sample_req_in <= 1'b1;
            sample_in <= s;
            @(posedge clock_in) sample_req_in <= 1'b0;
            repeat (2) @(posedge clock_in);
            repeat (16) @(posedge clock_in) bit_tick_in <= ~bit_tick_in;
            repeat (3) @(posedge clock_in);
            s = (i & 1) ? s : s ^ 16'h8000;
            #1 chk("serial word", rx_word, (i & 2) ? ~s : s);
            chk("frame dclk", rx_clk, 16'hf0aa);
        end
        complete_run();
    end
endmodule

// [bench/aofc_core_asserts.sv]
// Port-level checker for the output format control block
`timescale 1ns/1ps
module aofc_core_chk (
    input wire logic       clock_in,          // Clock
    input wire logic       nrst_in,           // Reset
    input wire logic       reg_wr_in,         // Write
    input wire logic       reg_rd_in,         // Read
    input wire logic [9:0] reg_addr_in,       // Address
    input wire logic [7:0] reg_wdata_in,      // Data
    input wire logic       div_active_in,     // Divider on
    input wire logic       sample_req_in,     // Sample
    input wire logic [7:0] reg_rdata_out,     // Read data
    input wire logic       sample_strobe_out, // Strobe
    input wire logic [3:0] dclk_mult_out,     // Multiple
    input wire logic       reduced_swing_out, // Swing
    input wire logic       clk_drive_2x_out,  // Drive
    input wire logic [1:0] termination_out,   // Termination
    input wire logic [3:0] out_clk_phase_out, // Phase
    input wire logic [9:0] out_clk_deg_out,   // Degrees
    input wire logic [7:0] rate_limit_out,    // Override
    input wire logic       pulldown_off_out,  // Pull-down off
    input wire logic       cm_gen_pd_out      // Common-mode off
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Outputs follow two edges after the write edge
    wire w14  = reg_wr_in && reg_addr_in == 10'h014;
    wire w21  = reg_wr_in && reg_addr_in == 10'h021;
    wire w100 = reg_wr_in && reg_addr_in == 10'h100;
    wire w101 = reg_wr_in && reg_addr_in == 10'h101;
    wire w102 = reg_wr_in && reg_addr_in == 10'h102;
    property p_link; w14 |-> ##2 reduced_swing_out == $past(reg_wdata_in[6], 2); endproperty
    a_link: assert property (p_link) else $error("Swing not as written");
    property p_pull; w101 |-> ##2 pulldown_off_out == $past(reg_wdata_in[0], 2); endproperty
    a_pull: assert property (p_pull) else $error("Pull-down not as written");
    property p_cmpd; w102 |-> ##2 cm_gen_pd_out == $past(reg_wdata_in[3], 2); endproperty
    a_cmpd: assert property (p_cmpd) else $error("Common-mode not as written");
    // The override must wait for the transfer bit
    property p_hold; w100 |-> ##1 $stable(rate_limit_out) [*2]; endproperty
    a_hold: assert property (p_hold) else $error("Override applied early");
    property p_term; clk_drive_2x_out |-> termination_out == 2'h0; endproperty
    a_term: assert property (p_term) else $error("Drive beside termination");
    property p_deg;
        out_clk_phase_out < 4'hc |-> out_clk_deg_out == {6'h0, out_clk_phase_out} * 10'h03c;
    endproperty
    a_deg: assert property (p_deg) else $error("Phase degrees wrong");
    property p_ddr; w21 && reg_wdata_in[6:5] == 2'b01 |-> ##2 dclk_mult_out == 4'h4; endproperty
    a_ddr: assert property (p_ddr) else $error("Double-rate multiple wrong");
    property p_strb; sample_req_in && !div_active_in |=> sample_strobe_out; endproperty
    a_strb: assert property (p_strb) else $error("Strobe not next cycle");
    property p_umap; reg_rd_in && reg_addr_in > 10'h102 |=> reg_rdata_out == 8'h00; endproperty
    a_umap: assert property (p_umap) else $error("Unmapped read not zero");
endmodule
bind aofc_core aofc_core_chk u_chk (.*);

// [bench/aofc_rx_model.sv]
// Receiver capture model: rebuilds each 16-bit word from the two lanes
`timescale 1ns/1ps
module aofc_rx_model (
    input  wire logic        clock_in,    // Clock
    input  wire logic        nrst_in,     // Reset
    input  wire logic        bit_tick_in, // Lane bit time
    input  wire logic [1:0]  lanes_in,    // Serial lanes
    input  wire logic        frame_in,    // Frame clock level
    input  wire logic        dclk_in,     // Data clock level
    output logic      [15:0] word_out,    // Last word
    output logic      [15:0] clk_out      // Frame levels high byte, data clock low byte
);
    logic        tick_q;
    logic [2:0]  cnt_q;
    logic [15:0] sh_q;
    logic [15:0] ck_q;
    // Lanes move on the tick edge, so sample one edge later; bytewise, MSB first
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_q <= 1'b0;
            cnt_q <= 3'h0;
            sh_q <= 16'h0000;
            word_out <= 16'h0000;
            ck_q <= 16'h0000;
            clk_out <= 16'h0000;
        end else begin
            tick_q <= bit_tick_in;
            if (tick_q) begin
                sh_q <= {sh_q[14:8], lanes_in[1], sh_q[6:0], lanes_in[0]};
                ck_q <= {ck_q[14:8], frame_in, ck_q[6:0], dclk_in};
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    word_out <= {sh_q[14:8], lanes_in[1], sh_q[6:0], lanes_in[0]};
                    clk_out <= {ck_q[14:8], frame_in, ck_q[6:0], dclk_in};
                end
            end
        end
    end
endmodule

// [hw/aofc_core.sv]
// Output format control: register file, sample coding, serializer and driver settings
//
// Functional notes
// R1 - Link bit selects reduced-range or standard swing
// R2 - Invert bit inverts every serial output bit
// R3 - Format defaults twos complement; cleared gives offset binary
// R4 - Drive bit doubles frame/data clock drive only
// R5 - Termination selection overrides 2x clock drive
// R6 - Two-bit field selects internal termination resistor
// R7 - Input phase delays sampling 0-7 cycles
// R8 - Software keeps phase within divide ratio
// R9 - Output clock phase in 60-degree steps
// R10 - Double-rate two-lane: data clock four times rate
// R11 - Single-rate two-lane: data clock eight times rate
// R12 - Sample sent as 16-bit word across lanes
// R13 - Rate override waits for transfer bit
// R14 - Override limits capability, never actual sampling
// R15 - User io 2 bit0 disables data pin pull-down
// R16 - User io 3 bit3 powers down common-mode generator
// R17 - Other registers take effect on write
// R18 - Software selects clock channels before per-channel write
// R19 - Offset binary by inverting the sample MSB
`timescale 1ns/1ps
`include "aofc_map.svh"
module aofc_core
    import aofc_pkg::*;
#(
    parameter int unsigned WORD_BITS = `AOFC_WORD_BITS
) (
    input  wire logic                  clock_in,          // 20 MHz system clock
    input  wire logic                  nrst_in,           // Asynchronous reset, active low
    input  wire logic                  reg_wr_in,         // Register write strobe
    input  wire logic                  reg_rd_in,         // Register read strobe
    input  wire logic [9:0]            reg_addr_in,       // Register address
    input  wire logic [7:0]            reg_wdata_in,      // Register write data
    input  wire logic [3:0]            clk_chan_sel_in,   // Output clock channels chosen
    input  wire logic [2:0]            div_ratio_in,      // Clock divider ratio field
    input  wire logic                  div_active_in,     // Clock divider in use
    input  wire logic                  sample_req_in,     // Sample clock edge (pulse)
    input  wire logic [WORD_BITS-1:0]  sample_in,         // Converted sample, twos complement
    input  wire logic                  bit_tick_in,       // Lane bit-time enable pulse
    output logic      [7:0]            reg_rdata_out,     // Register read data
    output logic                       sample_strobe_out, // Delayed sampling instant
    output logic      [1:0]            data_lane_pairs_out, // Serial lane bits
    output logic                       frame_clock_out,   // Frame marker
    output logic                       data_clock_out,    // Data clock level
    output logic      [3:0]            dclk_mult_out,     // Data clock multiple of fs (4 or 8)
    output logic                       reduced_swing_out, // Reduced-range link selected
    output logic                       clk_drive_2x_out,  // Frame/data clock 2x drive
    output logic      [1:0]            termination_out,   // Termination selection
    output logic      [3:0]            out_clk_phase_out, // Data clock phase code
    output logic      [9:0]            out_clk_deg_out,   // Data clock phase in degrees
    output logic      [7:0]            rate_limit_out,    // Active rate override setting
    output logic                       pulldown_off_out,  // Data pin pull-down disabled
    output logic                       cm_gen_pd_out      // Common-mode generator powered down
);
    logic [7:0] mode_q;
    logic [7:0] adjust_q;
    logic [7:0] phase_q;
    logic [7:0] ser_q;
    logic [7:0] rate_shadow_q;
    logic [7:0] rate_live_q;
    logic [7:0] uio2_q;
    logic [7:0] uio3_q;

    function automatic logic [9:0] phase_deg(input logic [3:0] code);
        phase_deg = 10'(code * `AOFC_PHASE_STEP_DEG);
    endfunction

    function automatic aofc_ser_mode_e decode_mode(input logic [7:0] ser);
        unique case (ser[`AOFC_SER_MODE_LSB +: 3])
            3'h0:    decode_mode = AOFC_SDR_BIT;
            3'h1:    decode_mode = AOFC_SDR_BYTE;
            3'h2:    decode_mode = AOFC_DDR_BIT;
            3'h3:    decode_mode = AOFC_DDR_BYTE;
            3'h4:    decode_mode = AOFC_DDR_WORD1;
            default: decode_mode = AOFC_RSVD;
        endcase
    endfunction

    // Immediate-effect registers
    // Unmapped writes fall through and change nothing
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_q   <= `AOFC_RST_OUTPUT_MODE;
            adjust_q <= `AOFC_RST_OUTPUT_ADJUST;
            phase_q  <= `AOFC_RST_OUTPUT_PHASE;
            ser_q    <= `AOFC_RST_SERIAL_CTRL;
            uio2_q   <= `AOFC_RST_ZERO;
            uio3_q   <= `AOFC_RST_ZERO;
        end else if (reg_wr_in) begin // [R17]
            unique case (reg_addr_in)
                `AOFC_REG_OUTPUT_MODE:   mode_q   <= reg_wdata_in;
                `AOFC_REG_OUTPUT_ADJUST: adjust_q <= reg_wdata_in;
                `AOFC_REG_OUTPUT_PHASE:  phase_q  <= reg_wdata_in;
                `AOFC_REG_SERIAL_CTRL:   ser_q    <= reg_wdata_in;
                `AOFC_REG_USER_IO_2:     uio2_q   <= reg_wdata_in;
                `AOFC_REG_USER_IO_3:     uio3_q   <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Rate override is double buffered; the live copy loads only on transfer
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rate_shadow_q <= `AOFC_RST_ZERO;
        end else if (reg_wr_in && reg_addr_in == `AOFC_REG_RATE_OVERRIDE) begin
            rate_shadow_q <= reg_wdata_in;
        end
    end

    // Transfer is write-only; it has no storage of its own
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rate_live_q <= `AOFC_RST_ZERO;
        end else if (reg_wr_in && reg_addr_in == `AOFC_REG_TRANSFER
                     && reg_wdata_in[`AOFC_XFER_BIT]) begin
            rate_live_q <= rate_shadow_q; // [R13]
        end
    end

    // Read back; transfer register reads zero as it has no storage
    // The override reads back its pending value, not the live one
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `AOFC_REG_OUTPUT_MODE:   reg_rdata_out <= mode_q;
                `AOFC_REG_OUTPUT_ADJUST: reg_rdata_out <= adjust_q;
                `AOFC_REG_OUTPUT_PHASE:  reg_rdata_out <= phase_q;
                `AOFC_REG_SERIAL_CTRL:   reg_rdata_out <= ser_q;
                `AOFC_REG_RATE_OVERRIDE: reg_rdata_out <= rate_shadow_q;
                `AOFC_REG_USER_IO_2:     reg_rdata_out <= uio2_q;
                `AOFC_REG_USER_IO_3:     reg_rdata_out <= uio3_q;
                default:                 reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Link standard and termination follow their bits directly
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reduced_swing_out <= 1'b0;
            termination_out   <= 2'b00;
        end else begin
            reduced_swing_out <= mode_q[`AOFC_MODE_LINK_BIT]; // [R1]
            termination_out   <= adjust_q[`AOFC_ADJ_TERM_LSB +: 2]; // [R6]
        end
    end

    // Drive applies only while at least one clock channel is selected; termination wins
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clk_drive_2x_out <= 1'b0;
        end else begin
            clk_drive_2x_out <= adjust_q[`AOFC_ADJ_DRIVE_BIT] && (|clk_chan_sel_in) // [R4] [R18]
                                && (adjust_q[`AOFC_ADJ_TERM_LSB +: 2] == 2'b00); // [R5]
        end
    end

    // Degrees are kept beside the code so the clock aligner needs no multiplier
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_clk_phase_out <= 4'h0;
            out_clk_deg_out   <= 10'h000;
        end else begin
            out_clk_phase_out <= phase_q[3:0];
            out_clk_deg_out   <= phase_deg(phase_q[3:0]); // [R9]
        end
    end

    // Pin and power controls; the override is only a capability ceiling
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rate_limit_out   <= 8'h00;
            pulldown_off_out <= 1'b0;
            cm_gen_pd_out    <= 1'b0;
        end else begin
            rate_limit_out   <= rate_live_q; // [R14]
            pulldown_off_out <= uio2_q[`AOFC_UIO2_PULLDOWN_BIT]; // [R15]
            cm_gen_pd_out    <= uio3_q[`AOFC_UIO3_CM_PD_BIT]; // [R16]
        end
    end

    // Data clock multiple; reserved codes fall back to the single-rate figure
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dclk_mult_out <= 4'h4;
        end else begin
            unique case (decode_mode(ser_q))
                AOFC_DDR_BIT, AOFC_DDR_BYTE: dclk_mult_out <= 4'h4; // [R10]
                default:                     dclk_mult_out <= 4'h8; // [R11]
            endcase
        end
    end

    // Input clock phase delay: hold sampling for the programmed cycle count.
    // A phase beyond the divide ratio is software's fault and is not trapped.
    // A request during a pending delay is ignored.
    // The field resets to zero, so sampling starts undelayed.
    logic [2:0] ph_cnt_q;
    logic       ph_busy_q;
    logic [2:0] ph_set;
    assign ph_set = div_active_in ? phase_q[`AOFC_PH_IN_LSB +: 3] : 3'h0; // [R8]

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ph_cnt_q          <= 3'h0;
            ph_busy_q         <= 1'b0;
            sample_strobe_out <= 1'b0;
        end else begin
            sample_strobe_out <= 1'b0;
            if (sample_req_in && !ph_busy_q) begin
                if (ph_set == 3'h0) sample_strobe_out <= 1'b1; // [R7]
                else begin
                    ph_cnt_q  <= ph_set;
                    ph_busy_q <= 1'b1;
                end
            end else if (ph_busy_q) begin
                if (ph_cnt_q == 3'h1) begin
                    ph_busy_q         <= 1'b0;
                    sample_strobe_out <= 1'b1; // [R7]
                end
                ph_cnt_q <= ph_cnt_q - 3'h1;
            end
        end
    end

    // Serializer: each sample becomes one 16-bit word spread over two lanes
    // A strobe that lands mid-word is dropped, so the sample rate must leave
    // a full word of bit ticks between strobes
    aofc_ser_state_e      st_q;
    logic [WORD_BITS-1:0] word_q;
    logic [3:0]           step_q;
    logic [WORD_BITS-1:0] coded;
    logic                 ddr;
    logic                 lsb_first;
    logic [3:0]           last_step;

    assign coded = mode_q[`AOFC_MODE_FORMAT_BIT] ? sample_in
                 : {~sample_in[WORD_BITS-1], sample_in[WORD_BITS-2:0]}; // [R3] [R19]
    assign ddr       = decode_mode(ser_q) inside {AOFC_DDR_BIT, AOFC_DDR_BYTE};
    assign lsb_first = ser_q[`AOFC_SER_LSB_FIRST_BIT];
    assign last_step = 4'(WORD_BITS/2 - 1);

    // Bytewise puts the high byte on lane 1; bitwise pairs adjacent bits
    function automatic logic [1:0] lane_bits(input logic [WORD_BITS-1:0] w,
                                             input logic [3:0] s, input logic bytew,
                                             input logic lsbf);
        logic [3:0] i;
        i = lsbf ? s : 4'(last_step - s);
        if (bytew) lane_bits = {w[8 + i[2:0]], w[i[2:0]]};   // [R12]
        else       lane_bits = {w[{i[2:0], 1'b1}], w[{i[2:0], 1'b0}]}; // [R12]
    endfunction

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q                <= AOFC_SER_IDLE;
            word_q              <= '0;
            step_q              <= 4'h0;
            data_lane_pairs_out <= 2'b00;
            frame_clock_out     <= 1'b0;
            data_clock_out      <= 1'b0;
        end else begin
            unique case (st_q)
                // Frame and data clocks hold their levels between words
                AOFC_SER_IDLE: begin
                    if (sample_strobe_out) begin
                        word_q <= coded;
                        step_q <= 4'h0;
                        st_q   <= AOFC_SER_SHIFT;
                    end
                end
                AOFC_SER_SHIFT: begin
                    if (bit_tick_in) begin
                        data_lane_pairs_out <= lane_bits(word_q, step_q,
                            ser_q[`AOFC_SER_MODE_LSB], lsb_first)
                            ^ {2{mode_q[`AOFC_MODE_INVERT_BIT]}}; // [R2]
                        // 2x frame toggles every quarter word, 1x every half word
                        frame_clock_out <= ser_q[`AOFC_SER_FRAME2X_BIT]
                            ? (step_q[1:0] < 2'h2) : (step_q < 4'h4);
                        data_clock_out  <= ddr ? ~data_clock_out : step_q[0];
                        if (step_q == last_step) begin
                            if (sample_strobe_out) begin
                                word_q <= coded;
                                step_q <= 4'h0;
                            end else begin
                                st_q <= AOFC_SER_IDLE;
                            end
                        end else begin
                            step_q <= step_q + 4'h1;
                        end
                    end
                end
                default: st_q <= AOFC_SER_IDLE;
            endcase
        end
    end
endmodule

// [shared/aofc_map.svh]
// Register offsets, field positions, reset values, word width and phase step of the output format block
`ifndef AOFC_MAP_SVH
`define AOFC_MAP_SVH
`define AOFC_REG_OUTPUT_MODE      10'h014
`define AOFC_REG_OUTPUT_ADJUST    10'h015
`define AOFC_REG_OUTPUT_PHASE     10'h016
`define AOFC_REG_SERIAL_CTRL      10'h021
`define AOFC_REG_TRANSFER         10'h0ff
`define AOFC_REG_RATE_OVERRIDE    10'h100
`define AOFC_REG_USER_IO_2        10'h101
`define AOFC_REG_USER_IO_3        10'h102
`define AOFC_MODE_LINK_BIT        6
`define AOFC_MODE_INVERT_BIT      2
`define AOFC_MODE_FORMAT_BIT      0
`define AOFC_ADJ_DRIVE_BIT        0
`define AOFC_ADJ_TERM_LSB         4
`define AOFC_PH_IN_LSB            4
`define AOFC_SER_LSB_FIRST_BIT    7
`define AOFC_SER_MODE_LSB         4
`define AOFC_SER_FRAME2X_BIT      2
`define AOFC_XFER_BIT             0
`define AOFC_UIO2_PULLDOWN_BIT    0
`define AOFC_UIO3_CM_PD_BIT       3
`define AOFC_RST_OUTPUT_MODE      8'h01
`define AOFC_RST_OUTPUT_ADJUST    8'h00
`define AOFC_RST_OUTPUT_PHASE     8'h00
`define AOFC_RST_SERIAL_CTRL      8'h30
`define AOFC_RST_ZERO             8'h00
`define AOFC_WORD_BITS            16
`define AOFC_PHASE_STEP_DEG       60
`endif

// [shared/aofc_pkg.sv]
// Types shared by the output format control block
package aofc_pkg;
    typedef enum logic [2:0] {
        AOFC_SDR_BIT, AOFC_SDR_BYTE, AOFC_DDR_BIT, AOFC_DDR_BYTE, AOFC_DDR_WORD1, AOFC_RSVD
    } aofc_ser_mode_e;
    typedef enum logic [1:0] { AOFC_SER_IDLE, AOFC_SER_SHIFT } aofc_ser_state_e;
endpackage
